/* File: core/ccd_pkg.sv */
// Constants and types for the core execution datapath
package ccd_pkg;
    localparam int unsigned REG_COUNT     = 32;
    localparam int unsigned DATA_WIDTH    = 8;
    localparam int unsigned ADDR_WIDTH    = 16;
    localparam logic [4:0]  PTR_X_LOW     = 5'h1A;
    localparam logic [4:0]  PTR_Y_LOW     = 5'h1C;
    localparam logic [4:0]  PTR_Z_LOW     = 5'h1E;
    localparam logic [15:0] PC_RESET      = 16'h0000;
    localparam logic [15:0] INSTR_RESET   = 16'h0000;
    localparam logic [7:0]  BYTE_ZERO     = 8'h00;
    localparam logic [15:0] PC_STEP       = 16'h0001;
    // Status flag positions
    localparam int unsigned FLAG_C        = 0;
    localparam int unsigned FLAG_Z        = 1;
    localparam int unsigned FLAG_N        = 2;
    localparam int unsigned FLAG_V        = 3;
    localparam int unsigned FLAG_S        = 4;
    localparam int unsigned FLAG_H        = 5;
    // Instruction word layout: op[15:12] d[11:7] r[6:2] sel[1:0]
    // Immediate forms: op[15:12] d[11:8] imm[7:0], target is 16 + d
    typedef enum logic [3:0] {
        CCD_OP_NOP  = 4'h0,
        CCD_OP_ADD  = 4'h1,
        CCD_OP_SUB  = 4'h2,
        CCD_OP_AND  = 4'h3,
        CCD_OP_OR   = 4'h4,
        CCD_OP_XOR  = 4'h5,
        CCD_OP_MOV  = 4'h6,
        CCD_OP_ADDI = 4'h7,
        CCD_OP_SUBI = 4'h8,
        CCD_OP_ANDI = 4'h9,
        CCD_OP_LDI  = 4'hA,
        CCD_OP_UNRY = 4'hB,
        CCD_OP_LD   = 4'hC,
        CCD_OP_ST   = 4'hD,
        CCD_OP_LPM  = 4'hE,
        CCD_OP_RSV  = 4'hF
    } ccd_op_type;
    typedef enum logic [1:0] {
        CCD_UN_INC = 2'b00,
        CCD_UN_DEC = 2'b01,
        CCD_UN_COM = 2'b10,
        CCD_UN_NEG = 2'b11
    } ccd_unary_type;
    typedef enum logic [1:0] {
        CCD_PTR_X = 2'b00,
        CCD_PTR_Y = 2'b01,
        CCD_PTR_Z = 2'b10,
        CCD_PTR_R = 2'b11
    } ccd_ptr_type;
    typedef enum logic [0:0] {
        CCD_ST_FILL = 1'b0,
        CCD_ST_RUN  = 1'b1
    } ccd_state_type;
endpackage : ccd_pkg

/* File: core/ccd_core.sv */
// Single-issue execution datapath with split program and data buses
//
// Overview of operation
// - Separate program and data buses, both usable in the same cycle.
// - Next instruction is fetched while the current one executes.
// - Single-cycle instructions complete one per clock.
// - Thirty-two 8-bit registers, each read or written in one cycle.
// - ALU reads two operands, computes, writes back in one cycle.
// - Six registers pair into three 16-bit data-space pointers.
// - One pointer pair also addresses program memory for table reads.
// - ALU does register-register, register-immediate and unary operations.
// - Status flags update after each arithmetic operation.
// - Pointer pairs are built from registers 26 to 31.
// - Sign flag always equals negative xor overflow.
`timescale 1ns/1ps
module ccd_core
    import ccd_pkg::*;
#(
    parameter int unsigned NUM_REGS = REG_COUNT
) (
    input  wire logic                  clk,
    input  wire logic                  sys_rst,
    output logic [ADDR_WIDTH-1:0]      prog_addr,
    input  wire logic [15:0]           prog_data,
    output logic [ADDR_WIDTH-1:0]      data_addr,
    output logic [DATA_WIDTH-1:0]      data_wdata,
    output logic                       data_we,
    output logic                       data_re,
    input  wire logic [DATA_WIDTH-1:0] data_rdata,
    output logic [7:0]                 status_flags,
    output logic                       instr_done
);
    if (NUM_REGS != REG_COUNT) begin : g_reg_count_check
        $error("ccd_core supports exactly 32 registers");
    end

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        ccd_state_type                        phase;
        logic [ADDR_WIDTH-1:0]                pc;
        logic [15:0]                          instr;
        logic [NUM_REGS-1:0][DATA_WIDTH-1:0]  regs;
        logic [7:0]                           sreg;
        logic                                 load_pend;
        logic                                 lpm_pend;
        logic                                 lpm_high;
        logic [4:0]                           load_dst;
        logic [ADDR_WIDTH-1:0]                prog_addr;
        logic [ADDR_WIDTH-1:0]                data_addr;
        logic [DATA_WIDTH-1:0]                data_wdata;
        logic                                 data_we;
        logic                                 data_re;
        logic                                 done;
    } ccd_core_type;

    ccd_core_type cur;
    ccd_core_type next_cur;

    // ------------------------------------------------------------
    // Decode and execute
    // ------------------------------------------------------------
    ccd_op_type            op;
    logic [4:0]            rd;
    logic [4:0]            rr;
    logic [4:0]            rd_imm;
    logic [7:0]            imm;
    logic [7:0]            opa;
    logic [7:0]            opb;
    logic [8:0]            sum;
    logic [7:0]            res;
    logic                  wr_en;
    logic [4:0]            wr_idx;
    logic                  arith;
    logic                  logic_op;
    logic                  sub_op;
    logic                  half;
    logic                  ovf;
    logic [ADDR_WIDTH-1:0] ptr;
    logic [ADDR_WIDTH-1:0] ptr_x;
    logic [ADDR_WIDTH-1:0] ptr_y;
    logic [ADDR_WIDTH-1:0] ptr_z;

    assign op     = ccd_op_type'(cur.instr[15:12]);
    assign rd     = cur.instr[11:7];
    assign rr     = cur.instr[6:2];
    assign rd_imm = {1'b1, cur.instr[11:8]};
    assign imm    = {cur.instr[7:0]};

    assign ptr_x = {cur.regs[PTR_X_LOW + 5'h01], cur.regs[PTR_X_LOW]};
    assign ptr_y = {cur.regs[PTR_Y_LOW + 5'h01], cur.regs[PTR_Y_LOW]};
    assign ptr_z = {cur.regs[PTR_Z_LOW + 5'h01], cur.regs[PTR_Z_LOW]};

    always_comb begin
        unique case (ccd_ptr_type'(cur.instr[1:0]))
            CCD_PTR_X: ptr = ptr_x;
            CCD_PTR_Y: ptr = ptr_y;
            CCD_PTR_Z: ptr = ptr_z;
            CCD_PTR_R: ptr = ptr_z;
        endcase
    end

    always_comb begin
        opa      = cur.regs[rd];
        opb      = cur.regs[rr];
        wr_idx   = rd;
        wr_en    = 1'b0;
        arith    = 1'b0;
        logic_op = 1'b0;
        sub_op   = 1'b0;
        res      = BYTE_ZERO;
        unique case (op)
            CCD_OP_ADDI, CCD_OP_SUBI, CCD_OP_ANDI, CCD_OP_LDI: begin
                opa    = cur.regs[rd_imm];
                opb    = imm;
                wr_idx = rd_imm;
            end
            CCD_OP_UNRY: begin
                unique case (ccd_unary_type'(cur.instr[1:0]))
                    CCD_UN_INC: opb = 8'h01;
                    CCD_UN_DEC: opb = 8'h01;
                    CCD_UN_COM: opb = 8'hFF;
                    CCD_UN_NEG: begin
                        opb = opa;
                        opa = BYTE_ZERO;
                    end
                endcase
            end
            default: begin
            end
        endcase
        unique case (op)
            CCD_OP_SUB, CCD_OP_SUBI: sub_op = 1'b1;
            CCD_OP_UNRY: sub_op = cur.instr[0];
            default: sub_op = 1'b0;
        endcase
        sum = sub_op ? ({1'b0, opa} - {1'b0, opb})
                     : ({1'b0, opa} + {1'b0, opb});
        unique case (op)
            CCD_OP_ADD, CCD_OP_SUB, CCD_OP_ADDI, CCD_OP_SUBI: begin
                res = sum[7:0];
                wr_en = 1'b1;
                arith = 1'b1;
            end
            CCD_OP_UNRY: begin
                res = (cur.instr[1:0] == CCD_UN_COM) ? (opa ^ opb) : sum[7:0];
                wr_en = 1'b1;
                arith = (cur.instr[1:0] != CCD_UN_COM);
                logic_op = (cur.instr[1:0] == CCD_UN_COM);
            end
            CCD_OP_AND, CCD_OP_ANDI: begin
                res = opa & opb;
                wr_en = 1'b1;
                logic_op = 1'b1;
            end
            CCD_OP_OR: begin
                res = opa | opb;
                wr_en = 1'b1;
                logic_op = 1'b1;
            end
            CCD_OP_XOR: begin
                res = opa ^ opb;
                wr_en = 1'b1;
                logic_op = 1'b1;
            end
            CCD_OP_MOV: begin
                res = opb;
                wr_en = 1'b1;
            end
            CCD_OP_LDI: begin
                res = opb;
                wr_en = 1'b1;
            end
            default: begin
            end
        endcase
        half = sub_op ? ((~opa[3] & opb[3]) | (opb[3] & res[3]) | (res[3] & ~opa[3]))
                      : ((opa[3] & opb[3]) | (opb[3] & ~res[3]) | (~res[3] & opa[3]));
        ovf  = sub_op ? ((opa[7] & ~opb[7] & ~res[7]) | (~opa[7] & opb[7] & res[7]))
                      : ((opa[7] & opb[7] & ~res[7]) | (~opa[7] & ~opb[7] & res[7]));
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        next_cur            = cur;
        next_cur.data_we    = 1'b0;
        next_cur.data_re    = 1'b0;
        next_cur.done       = 1'b0;
        next_cur.load_pend  = 1'b0;
        next_cur.lpm_pend   = 1'b0;
        // Results of last cycle's data or table read land here
        if (cur.load_pend) begin
            next_cur.regs[cur.load_dst] = data_rdata;
        end
        if (cur.lpm_pend) begin
            next_cur.regs[cur.load_dst] = cur.lpm_high ? prog_data[15:8]
                                                       : prog_data[7:0];
        end
        unique case (cur.phase)
            CCD_ST_FILL: begin
                next_cur.phase     = CCD_ST_RUN;
                next_cur.pc        = cur.pc + PC_STEP;
                next_cur.prog_addr = cur.pc + PC_STEP;
                next_cur.instr     = prog_data;
            end
            CCD_ST_RUN: begin
                if (op == CCD_OP_LPM) begin
                    // Program bus lent to the table read for one cycle
                    next_cur.prog_addr = {1'b0, ptr_z[15:1]};
                    next_cur.lpm_pend  = 1'b1;
                    next_cur.lpm_high  = ptr_z[0];
                    next_cur.load_dst  = rd;
                    next_cur.instr     = INSTR_RESET;
                    next_cur.done      = 1'b1;
                end else begin
                    // Fetch overlaps execute
                    if (!cur.lpm_pend) begin
                        next_cur.instr     = prog_data;
                        next_cur.pc        = cur.pc + PC_STEP;
                        next_cur.prog_addr = cur.pc + PC_STEP;
                    end else begin
                        next_cur.prog_addr = cur.pc;
                        next_cur.instr     = INSTR_RESET;
                    end
                    next_cur.done = !cur.lpm_pend;
                    if (wr_en) begin
                        next_cur.regs[wr_idx] = res;
                    end
                    if (op == CCD_OP_LD || op == CCD_OP_ST) begin
                        next_cur.data_addr  = ptr;
                        next_cur.data_wdata = opa;
                        next_cur.data_we    = (op == CCD_OP_ST);
                        next_cur.data_re    = (op == CCD_OP_LD);
                        next_cur.load_pend  = (op == CCD_OP_LD);
                        next_cur.load_dst   = rd;
                    end
                    if (arith || logic_op) begin
                        next_cur.sreg[FLAG_Z] = (res == BYTE_ZERO);
                        next_cur.sreg[FLAG_N] = res[7];
                        next_cur.sreg[FLAG_V] = arith ? ovf : 1'b0;
                        next_cur.sreg[FLAG_S] = res[7] ^ (arith ? ovf : 1'b0);
                        if (arith && !(op == CCD_OP_UNRY && !cur.instr[1])) begin
                            next_cur.sreg[FLAG_C] = sum[8];
                            next_cur.sreg[FLAG_H] = half;
                        end
                    end
                end
            end
        endcase
        if (sys_rst) begin
            next_cur           = '0;
            next_cur.phase     = CCD_ST_FILL;
            next_cur.pc        = PC_RESET;
            next_cur.prog_addr = PC_RESET;
            next_cur.instr     = INSTR_RESET;
        end
    end

    always_ff @(posedge clk) begin
        cur <= next_cur;
    end

    assign prog_addr    = cur.prog_addr;
    assign data_addr    = cur.data_addr;
    assign data_wdata   = cur.data_wdata;
    assign data_we      = cur.data_we;
    assign data_re      = cur.data_re;
    assign status_flags = cur.sreg;
    assign instr_done   = cur.done;
endmodule : ccd_core

/* File: testbench/ccd_core_props.sv */
// Concurrent checks on the core datapath ports
`timescale 1ns/1ps
module ccd_core_props
    import ccd_pkg::*;
#(
    parameter int unsigned NUM_REGS = REG_COUNT
) (
    input wire logic                  clk,
    input wire logic                  sys_rst,
    input wire logic [ADDR_WIDTH-1:0] prog_addr,
    input wire logic [15:0]           prog_data,
    input wire logic [ADDR_WIDTH-1:0] data_addr,
    input wire logic [DATA_WIDTH-1:0] data_wdata,
    input wire logic                  data_we,
    input wire logic                  data_re,
    input wire logic [DATA_WIDTH-1:0] data_rdata,
    input wire logic [7:0]            status_flags,
    input wire logic                  instr_done
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    a_reset_quiet: assert property ($fell(sys_rst) |->
        prog_addr == PC_RESET && !instr_done && status_flags == 8'h00)
        else $error("outputs not cleared by reset");
    a_fetch_first: assert property ($fell(sys_rst) |->
        ##1 prog_addr == PC_STEP)
        else $error("fetch did not step after reset");
    a_fill_idle: assert property ($fell(sys_rst) |->
        (!data_we && !data_re) [*2])
        else $error("data strobe during pipeline fill");
    a_first_done: assert property ($fell(sys_rst) |->
        ##[1:4] instr_done)
        else $error("first instruction not completed in time");
    a_sign_flag: assert property (
        status_flags[FLAG_S] == (status_flags[FLAG_N] ^ status_flags[FLAG_V]))
        else $error("sign flag differs from negative xor overflow");
    a_flag_spare: assert property (status_flags[7:6] == 2'b00)
        else $error("unused status bits set");
    a_zero_not_neg: assert property (
        status_flags[FLAG_Z] |-> !status_flags[FLAG_N])
        else $error("zero and negative both set");
    a_bus_exclusive: assert property (!(data_we && data_re))
        else $error("load and store strobes together");
endmodule : ccd_core_props

bind ccd_core ccd_core_props #(.NUM_REGS(NUM_REGS)) chk_u (
    .clk(clk), .sys_rst(sys_rst), .prog_addr(prog_addr),
    .prog_data(prog_data), .data_addr(data_addr), .data_wdata(data_wdata),
    .data_we(data_we), .data_re(data_re), .data_rdata(data_rdata),
    .status_flags(status_flags), .instr_done(instr_done)
);

/* File: testbench/ccd_mem_model.sv */
// Program and data memory model on the far side of the core buses
`timescale 1ns/1ps
module ccd_mem_model (
    input  wire logic        clk,
    input  wire logic [15:0] prog_addr,
    output logic      [15:0] prog_data,
    input  wire logic [15:0] data_addr,
    input  wire logic [7:0]  data_wdata,
    input  wire logic        data_we,
    input  wire logic        data_re,
    output logic      [7:0]  data_rdata
);
    logic [15:0] rom [0:65535];
    logic [7:0]  ram [0:65535];
    // Both ports read without delay; the core registers the addresses
    assign prog_data = rom[prog_addr];
    // Released data bus shows the inverse of the addressed byte
    assign data_rdata = data_re ? ram[data_addr] : ~ram[data_addr];
    always @(posedge clk) begin
        if (data_we) begin
            ram[data_addr] <= data_wdata;
        end
    end
endmodule : ccd_mem_model

/* File: testbench/cpu_core_datapath_tb.sv */
// Self-checking bench for the core execution datapath
`timescale 1ns/1ps
`define CHECK(a, b) begin samples_checked++; if ((a) !== (b)) begin \
    n_errors++; $display("unexpected at %0t: %h", $time, (a)); end end
module cpu_core_datapath_tb;
    import ccd_pkg::*;
    logic        clk;
    logic        sys_rst;
    logic [15:0] prog_addr;
    logic [15:0] prog_data;
    logic [15:0] data_addr;
    logic [7:0]  data_wdata;
    logic        data_we;
    logic        data_re;
    logic [7:0]  data_rdata;
    logic [7:0]  status_flags;
    logic        instr_done;
    int          n_errors = 0;
    int          samples_checked = 0;
    int          cyc;
    int          cyc_we;
    int          n_done;

    ccd_core dut_u (.clk(clk), .sys_rst(sys_rst), .prog_addr(prog_addr),
        .prog_data(prog_data), .data_addr(data_addr),
        .data_wdata(data_wdata), .data_we(data_we), .data_re(data_re),
        .data_rdata(data_rdata), .status_flags(status_flags),
        .instr_done(instr_done));
    ccd_mem_model mem_u (.clk(clk), .prog_addr(prog_addr),
        .prog_data(prog_data), .data_addr(data_addr),
        .data_wdata(data_wdata), .data_we(data_we), .data_re(data_re),
        .data_rdata(data_rdata));

    initial clk = 1'b0;
    always #5 clk = ~clk;
    // Cycle of the first store and count of completed instructions
    always @(posedge clk) begin
        if (sys_rst) begin
            cyc <= 0;
            cyc_we <= 0;
            n_done <= 0;
        end else begin
            cyc <= cyc + 1;
            if (data_we === 1'b1 && cyc_we == 0) cyc_we <= cyc + 1;
            if (instr_done === 1'b1) n_done <= n_done + 1;
        end
    end

    // ----------------------------------------------------------------
    // Encoders, program loader and closing
    // ----------------------------------------------------------------
    function automatic logic [15:0] ldi(input logic [4:0] d,
                                        input logic [7:0] k);
        return {CCD_OP_LDI, d[3:0], k};
    endfunction : ldi
    function automatic logic [15:0] ri(input ccd_op_type op,
        input logic [4:0] d, input logic [7:0] k);
        return {op, d[3:0], k};
    endfunction : ri
    function automatic logic [15:0] rr(input ccd_op_type op,
        input logic [4:0] d, input logic [4:0] r, input logic [1:0] s);
        return {op, d, r, s};
    endfunction : rr
    task automatic run_prog(input logic [15:0] prog [$]);
        int i;
        sys_rst <= 1'b1;
        @(posedge clk);
        for (i = 0; i < 64; i++) mem_u.rom[i] = 16'h0000;
        foreach (prog[j]) mem_u.rom[j] = prog[j];
        @(posedge clk);
        sys_rst <= 1'b0;
        repeat (30) @(posedge clk);
    endtask : run_prog
    task automatic end_sim;
        if (n_errors == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : end_sim

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_alu;
        run_prog('{ldi(5'h10, 8'h7F), ldi(5'h11, 8'h01),
            rr(CCD_OP_ADD, 5'h10, 5'h11, 2'b00), ldi(5'h1A, 8'h34),
            ldi(5'h1B, 8'h12), rr(CCD_OP_ST, 5'h10, 5'h00, CCD_PTR_X)});
        `CHECK(mem_u.ram[16'h1234], 8'h80)
        `CHECK(status_flags, 8'h2C)
        `CHECK(cyc_we, 8)
        `CHECK(n_done, 27)
    endtask : t_alu
    task automatic t_sub;
        run_prog('{ldi(5'h12, 8'h00), ldi(5'h13, 8'hFE),
            rr(CCD_OP_UNRY, 5'h13, 5'h00, CCD_UN_COM),
            rr(CCD_OP_SUB, 5'h12, 5'h13, 2'b00), ldi(5'h1C, 8'h10),
            ldi(5'h1D, 8'h00), rr(CCD_OP_ST, 5'h12, 5'h00, CCD_PTR_Y)});
        `CHECK(mem_u.ram[16'h0010], 8'hFF)
        `CHECK(status_flags, 8'h35)
    endtask : t_sub
    task automatic t_mem;
        mem_u.ram[16'h0200] = 8'h5A;
        mem_u.rom[16'h0100] = 16'hC3A5;
        run_prog('{ldi(5'h1E, 8'h00), ldi(5'h1F, 8'h02),
            rr(CCD_OP_LD, 5'h14, 5'h00, CCD_PTR_Z), ldi(5'h1E, 8'h01),
            rr(CCD_OP_LPM, 5'h15, 5'h00, 2'b00), ldi(5'h1A, 8'h00),
            ldi(5'h1B, 8'h03), rr(CCD_OP_ST, 5'h14, 5'h00, CCD_PTR_X),
            ldi(5'h1A, 8'h01), rr(CCD_OP_ST, 5'h15, 5'h00, CCD_PTR_X)});
        `CHECK(mem_u.ram[16'h0300], 8'h5A)
        `CHECK(mem_u.ram[16'h0301], 8'hC3)
        `CHECK(n_done, 26)
    endtask : t_mem
    task automatic t_ops;
        run_prog('{ldi(5'h10, 8'h0F), ri(CCD_OP_ADDI, 5'h10, 8'h01),
            ri(CCD_OP_SUBI, 5'h10, 8'h20), ri(CCD_OP_ANDI, 5'h10, 8'h3C),
            rr(CCD_OP_UNRY, 5'h10, 5'h00, CCD_UN_INC),
            rr(CCD_OP_UNRY, 5'h10, 5'h00, CCD_UN_NEG),
            rr(CCD_OP_RSV, 5'h10, 5'h11, 2'b00), ldi(5'h11, 8'h5A),
            rr(CCD_OP_AND, 5'h11, 5'h10, 2'b00),
            rr(CCD_OP_XOR, 5'h11, 5'h10, 2'b00), ldi(5'h12, 8'h30),
            rr(CCD_OP_OR, 5'h12, 5'h11, 2'b00),
            rr(CCD_OP_MOV, 5'h13, 5'h12, 2'b00),
            rr(CCD_OP_UNRY, 5'h13, 5'h00, CCD_UN_DEC), ldi(5'h1B, 8'h04),
            ldi(5'h1A, 8'h00), rr(CCD_OP_ST, 5'h10, 5'h00, CCD_PTR_X),
            ldi(5'h1A, 8'h01), rr(CCD_OP_ST, 5'h11, 5'h00, CCD_PTR_X),
            ldi(5'h1A, 8'h02), rr(CCD_OP_ST, 5'h13, 5'h00, CCD_PTR_X)});
        `CHECK(mem_u.ram[16'h0400], 8'hCF)
        `CHECK(mem_u.ram[16'h0401], 8'h85)
        `CHECK(mem_u.ram[16'h0402], 8'hB4)
        `CHECK(status_flags, 8'h35)
    endtask : t_ops

    initial begin
        sys_rst <= 1'b1;
        repeat (20) @(posedge clk);
        t_alu();
        t_sub();
        t_mem();
        t_ops();
        end_sim();
    end
    initial begin
        repeat (2000) @(posedge clk);
        n_errors++;
        end_sim();
    end
endmodule : cpu_core_datapath_tb
